// ### pbst_pkg.sv
// Purpose: shared constants and types of the packet self-test block
// Assumes: 50 MHz reference clock, 5-bit management register addresses
// Notes: register offsets are management register numbers
package pbst_pkg;
    // management register numbers
    localparam logic [4:0] REG_CNT_VIEW = 5'h18; // self_test_count_view
    localparam logic [4:0] REG_CFG_ONE = 5'h19; // self_test_config_one
    localparam logic [4:0] REG_CFG_TWO = 5'h1a; // self_test_config_two
    // self_test_config_one fields
    localparam int C1_CNT_TYPE = 15; // 1 error counter, 0 packet counter
    localparam int C1_CNT_CLR = 14; // write 1 clears active counter
    localparam int C1_LONG = 13; // 1 long frames
    localparam int C1_GAP_LONG = 12; // 1 long gap
    localparam int C1_TX_EN = 11; // generator enable, self clearing after a counted run
    localparam int C1_PRBS = 10; // 1 pseudo random payload
    localparam int C1_USER_MSB = 7; // user byte msb
    // self_test_config_two fields
    localparam int C2_CNT_EN = 15; // counter enable
    localparam int C2_CNT_HI = 14; // 1 shows upper half
    localparam int C2_NUM_MSB = 13; // packet count code msb
    localparam int C2_NUM_LSB = 11; // packet count code lsb
    // reset values
    localparam logic [15:0] CFG_ONE_RST = 16'h0000; // generator and counter idle
    localparam logic [15:0] CFG_TWO_RST = 16'h0000; // counter disabled
    localparam logic [8:0] PRBS_SEED = 9'h1ff; // nonzero lfsr seed
    // frame lengths in bytes
    localparam logic [10:0] LEN_SHORT = 11'd60; // short frame
    localparam logic [10:0] LEN_LONG = 11'd1514; // long frame
    // gap times in ns and their least cycle counts
    localparam int CLK_PERIOD_NS = 20; // reference clock period
    localparam int GAP_LONG_NS = 9600; // 9.6 us
    localparam int GAP_SHORT_NS = 96; // 0.096 us
    localparam logic [9:0] GAP_LONG_CYC = 10'((GAP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] GAP_SHORT_CYC = 10'((GAP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // packet count codes and totals
    localparam logic [2:0] NUM_CONT = 3'h0; // continuous
    localparam logic [23:0] NUM_1 = 24'd1; // code 1
    localparam logic [23:0] NUM_10 = 24'd10; // code 2
    localparam logic [23:0] NUM_100 = 24'd100; // code 3
    localparam logic [23:0] NUM_1K = 24'd1000; // code 4
    localparam logic [23:0] NUM_10K = 24'd10000; // code 5
    localparam logic [23:0] NUM_100K = 24'd100000; // code 6
    localparam logic [23:0] NUM_10M = 24'd10000000; // code 7
    // one byte on a media-independent data path
    typedef struct packed {
        logic en; // frame valid
        logic er; // error
        logic [7:0] data; // byte
    } pbst_byte_t;
    localparam pbst_byte_t BYTE_IDLE = '{en: 1'b0, er: 1'b0, data: 8'h00}; // idle path
endpackage : pbst_pkg

// ### pbst_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full drops in_ready, empty drops out_valid
`timescale 1ns/1ps
module pbst_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk, // reference clock
    input wire logic rst, // async reset, active high
    input wire logic in_valid, // write request
    output logic in_ready, // room available
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // read request
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH); // pointer width
    logic [WIDTH-1:0] mem [DEPTH]; // storage
    logic [AW-1:0] wr_ptr; // write pointer
    logic [AW-1:0] rd_ptr; // read pointer
    logic [AW:0] fill; // words held
    logic push; // accepted write
    logic pop; // accepted read

    // handshakes from the fill level
    always_comb begin
        in_ready = (fill != (AW+1)'(DEPTH));
        out_valid = (fill != '0);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        out_data = mem[rd_ptr];
    end

    // pointers and fill count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage has no reset
    always_ff @(posedge ref_clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule : pbst_fifo

// ### pbst_core.sv
// Purpose: receive counter and transmit packet generator of the phy self test
// Assumes: link clock sampled by ref_clk, media receive path on ref_clk
// Notes: one byte moves per detected link clock rising edge
`timescale 1ns/1ps
module pbst_core #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic ref_clk, // reference clock
    input wire logic rst, // async reset, active high
    input wire logic link_clk_pin, // mac transmit clock pin
    input wire pbst_pkg::pbst_byte_t mac_tx, // mac transmit pins
    input wire pbst_pkg::pbst_byte_t med_rx, // media receive path
    input wire logic loopback_en, // loopback control level
    input wire logic [4:0] mgmt_addr, // register number
    input wire logic mgmt_wr, // write strobe
    input wire logic mgmt_rd, // read strobe
    input wire logic [15:0] mgmt_wdata, // write data
    output logic [15:0] mgmt_rdata, // read data, registered
    output pbst_pkg::pbst_byte_t med_tx, // media transmit path
    output pbst_pkg::pbst_byte_t mac_rx, // mac receive pins
    output logic bist_busy // generator running
);
    import pbst_pkg::*;

    typedef enum logic [1:0] {GEN_IDLE, GEN_SEND, GEN_GAP} pbst_gen_t;

    // link clock sampling
    logic [2:0] lclk_s; // three stage sampler
    logic lclk_lvl; // agreed level
    logic link_rise; // one cycle per rising edge
    pbst_byte_t mtx_s0, mtx_s1, mtx_s2; // mac transmit sampler
    // registers
    logic [15:0] cfg_one, next_cfg_one; // config one
    logic [15:0] cfg_two, next_cfg_two; // config two
    logic [31:0] rx_cnt, next_rx_cnt; // receive counter
    logic [15:0] next_rdata; // read data
    logic [15:0] view_val; // selected counter half
    logic prev_dv, prev_er; // previous mac receive levels
    logic pkt_ev, err_ev, sel_ev; // receive events
    logic cnt_clr; // clear write
    // generator
    pbst_gen_t state, next_state; // generator state
    logic [10:0] byte_cnt, next_byte_cnt; // byte in frame
    logic [9:0] gap_cnt, next_gap_cnt; // gap cycles
    logic [23:0] pkt_cnt, next_pkt_cnt; // frames sent
    logic [8:0] lfsr, next_lfsr; // payload lfsr
    logic [23:0] target; // frames to send
    logic [10:0] frame_len; // bytes per frame
    logic [9:0] gap_cyc; // gap length
    logic gen_done; // last frame finished
    logic is_last; // last byte of frame
    logic fifo_in_valid, fifo_in_ready; // generator side
    logic [8:0] fifo_in_data; // {byte, last}
    logic fifo_out_valid, fifo_out_ready; // drain side
    logic [8:0] fifo_out_data; // head
    // data path
    pbst_byte_t tx_byte, next_tx_byte; // byte on the transmit path
    pbst_byte_t next_med_tx, next_mac_rx; // output next values

    // sample link clock and mac transmit pins, stage 0 feeds only stage 1
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lclk_s <= 3'h0;
            lclk_lvl <= 1'b0;
            mtx_s0 <= BYTE_IDLE;
            mtx_s1 <= BYTE_IDLE;
            mtx_s2 <= BYTE_IDLE;
        end else begin
            lclk_s <= {lclk_s[1:0], link_clk_pin};
            if (lclk_s[1] == lclk_s[2]) lclk_lvl <= lclk_s[2];
            mtx_s0 <= mac_tx;
            mtx_s1 <= mtx_s0;
            mtx_s2 <= mtx_s1;
        end
    end
    // edge counts once stages two and three agree; speed set by that clock
    assign link_rise = (lclk_s[1] == lclk_s[2]) && lclk_s[2] && !lclk_lvl;

    // receive events seen on the mac receive stream, read only
    always_comb begin
        pkt_ev = prev_dv && !mac_rx.en;
        err_ev = mac_rx.er && !prev_er;
        sel_ev = cfg_one[C1_CNT_TYPE] ? err_ev : pkt_ev;
        cnt_clr = mgmt_wr && (mgmt_addr == REG_CFG_ONE) && mgmt_wdata[C1_CNT_CLR];
        view_val = cfg_two[C2_CNT_HI] ? rx_cnt[31:16] : rx_cnt[15:0];
    end

    // register writes, counter and read data next values
    always_comb begin
        next_cfg_one = cfg_one;
        next_cfg_two = cfg_two;
        next_rx_cnt = rx_cnt;
        next_rdata = mgmt_rdata;
        // hardware clears enable when the counted run ends
        if (gen_done) next_cfg_one[C1_TX_EN] = 1'b0;
        if (mgmt_wr && mgmt_addr == REG_CFG_ONE) begin
            // software write wins over the self clear
            next_cfg_one = mgmt_wdata;
            next_cfg_one[C1_CNT_CLR] = 1'b0;
            next_cfg_one[9:8] = 2'h0;
        end
        if (mgmt_wr && mgmt_addr == REG_CFG_TWO) begin
            next_cfg_two = mgmt_wdata;
        end
        // counter: clear, then event, never wrap
        if (cnt_clr) begin
            next_rx_cnt = (cfg_two[C2_CNT_EN] && sel_ev) ? 32'h1 : 32'h0;
        end else if (cfg_two[C2_CNT_EN] && sel_ev && rx_cnt != 32'hffffffff) begin
            next_rx_cnt = rx_cnt + 32'h1;
        end
        if (mgmt_rd) begin
            case (mgmt_addr)
                REG_CNT_VIEW: next_rdata = view_val;
                REG_CFG_ONE: next_rdata = cfg_one;
                REG_CFG_TWO: next_rdata = cfg_two;
                default: next_rdata = 16'h0000; // unmapped read as zero
            endcase
        end
    end

    // register state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_one <= CFG_ONE_RST;
            cfg_two <= CFG_TWO_RST;
            rx_cnt <= 32'h0;
            mgmt_rdata <= 16'h0000;
            prev_dv <= 1'b0;
            prev_er <= 1'b0;
        end else begin
            cfg_one <= next_cfg_one;
            cfg_two <= next_cfg_two;
            rx_cnt <= next_rx_cnt;
            mgmt_rdata <= next_rdata;
            prev_dv <= mac_rx.en;
            prev_er <= mac_rx.er;
        end
    end

    // generator settings decoded from config
    always_comb begin
        frame_len = cfg_one[C1_LONG] ? LEN_LONG : LEN_SHORT;
        gap_cyc = cfg_one[C1_GAP_LONG] ? GAP_LONG_CYC : GAP_SHORT_CYC;
        case (cfg_two[C2_NUM_MSB:C2_NUM_LSB])
            3'h1: target = NUM_1;
            3'h2: target = NUM_10;
            3'h3: target = NUM_100;
            3'h4: target = NUM_1K;
            3'h5: target = NUM_10K;
            3'h6: target = NUM_100K;
            3'h7: target = NUM_10M;
            default: target = 24'h0; // continuous
        endcase
    end

    // generator next state: frames into the fifo, then the gap
    always_comb begin
        logic [8:0] l;
        logic [7:0] pay;
        l = lfsr;
        pay = cfg_one[C1_PRBS] ? lfsr[7:0] : cfg_one[C1_USER_MSB:0];
        next_state = state;
        next_byte_cnt = byte_cnt;
        next_gap_cnt = gap_cnt;
        next_pkt_cnt = pkt_cnt;
        next_lfsr = lfsr;
        gen_done = 1'b0;
        is_last = (byte_cnt == frame_len - 11'd1);
        fifo_in_valid = (state == GEN_SEND);
        fifo_in_data = {pay, is_last};
        // eight steps of x^9 + x^5 + 1 per byte
        for (int i = 0; i < 8; i++) begin
            l = {l[7:0], l[8] ^ l[4]};
        end
        case (state)
            GEN_IDLE: begin
                next_byte_cnt = 11'h0;
                next_pkt_cnt = 24'h0;
                if (cfg_one[C1_TX_EN]) next_state = GEN_SEND;
            end
            GEN_SEND: begin
                if (fifo_in_ready) begin
                    next_byte_cnt = byte_cnt + 11'd1;
                    if (cfg_one[C1_PRBS]) next_lfsr = l;
                    if (is_last) begin
                        next_pkt_cnt = pkt_cnt + 24'd1;
                        next_gap_cnt = 10'h0;
                        next_state = GEN_GAP;
                    end
                end
            end
            GEN_GAP: begin
                // gap counts once the last byte has left the transmit path,
                // else a gap shorter than a link period merges two frames
                if (!fifo_out_valid && !tx_byte.en) begin
                    if (gap_cnt == gap_cyc - 10'd1) begin
                        next_byte_cnt = 11'h0;
                        if (target != 24'h0 && pkt_cnt >= target) begin
                            gen_done = 1'b1;
                            next_state = GEN_IDLE;
                        end else if (!cfg_one[C1_TX_EN]) begin
                            next_state = GEN_IDLE;
                        end else begin
                            next_state = GEN_SEND;
                        end
                    end else begin
                        next_gap_cnt = gap_cnt + 10'd1;
                    end
                end
            end
            default: next_state = GEN_IDLE;
        endcase
    end

    // generator state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= GEN_IDLE;
            byte_cnt <= 11'h0;
            gap_cnt <= 10'h0;
            pkt_cnt <= 24'h0;
            lfsr <= PRBS_SEED;
        end else begin
            state <= next_state;
            byte_cnt <= next_byte_cnt;
            gap_cnt <= next_gap_cnt;
            pkt_cnt <= next_pkt_cnt;
            lfsr <= next_lfsr;
        end
    end

    // byte buffer between generator and link-paced drain
    pbst_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // data path: transmit byte chosen per link edge, outputs steered
    always_comb begin
        bist_busy = (state != GEN_IDLE);
        fifo_out_ready = link_rise && bist_busy;
        next_tx_byte = tx_byte;
        if (link_rise) begin
            if (bist_busy) begin
                // mac transmit pins ignored while generating
                next_tx_byte = BYTE_IDLE;
                if (fifo_out_valid) next_tx_byte = '{en: 1'b1, er: 1'b0,
                                                     data: fifo_out_data[8:1]};
            end else begin
                next_tx_byte = mtx_s2;
            end
        end
        // loopback keeps the media idle and feeds the mac
        next_med_tx = loopback_en ? BYTE_IDLE : tx_byte;
        next_mac_rx = loopback_en ? tx_byte : med_rx;
    end

    // data path registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_byte <= BYTE_IDLE;
            med_tx <= BYTE_IDLE;
            mac_rx <= BYTE_IDLE;
        end else begin
            tx_byte <= next_tx_byte;
            med_tx <= next_med_tx;
            mac_rx <= next_mac_rx;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_last_push;
        fifo_in_valid && fifo_in_ready && is_last;
    endsequence
    AST_VIEW_HALF: assert property (mgmt_rd && mgmt_addr == REG_CNT_VIEW
        |=> mgmt_rdata == $past(view_val)) else $error("count view wrong half");
    AST_COUNT_SEL: assert property (cfg_two[C2_CNT_EN] && !cnt_clr && sel_ev
        && rx_cnt != 32'hffffffff |=> rx_cnt == $past(rx_cnt) + 32'h1)
        else $error("selected event not counted");
    AST_CLEAR: assert property (cnt_clr |=> rx_cnt <= 32'h1)
        else $error("counter not cleared");
    AST_HOLD_OFF: assert property (!cfg_two[C2_CNT_EN] && !cnt_clr
        |=> $stable(rx_cnt)) else $error("disabled counter moved");
    AST_PAYLOAD: assert property (fifo_in_valid && !cfg_one[C1_PRBS]
        |-> fifo_in_data[8:1] == cfg_one[7:0]) else $error("user payload wrong");
    AST_LENGTH: assert property (s_last_push
        |-> byte_cnt == (cfg_one[C1_LONG] ? 11'd1513 : 11'd59)) else $error("frame length wrong");
    AST_GAP_MIN: assert property (state == GEN_GAP && !fifo_out_valid && !tx_byte.en
        && gap_cnt == 10'h0 |-> (state == GEN_GAP) [*5]) else $error("gap too short");
    AST_SELF_CLEAR: assert property (gen_done && !mgmt_wr
        |=> !cfg_one[C1_TX_EN] && state == GEN_IDLE) else $error("enable not cleared");
    AST_IGNORE_MAC: assert property (link_rise && bist_busy
        |=> tx_byte.en == $past(fifo_out_valid)) else $error("mac data leaked");
    AST_LOOPBACK: assert property (loopback_en |=> !med_tx.en && mac_rx == $past(tx_byte))
        else $error("loopback path wrong");
endmodule : pbst_core

// ### pbst_mac_model.sv
// Purpose: mac-side partner of the packet self-test block, plus a stream monitor
// Assumes: mac launches bytes on the rising edge of its transmit clock
// Notes: released data lines carry a changing pattern, never the last byte
`timescale 1ns/1ps
module pbst_mac_model #(
    parameter int HALF_NS = 80 // half period of the transmit clock
) (
    input wire logic run, // let the transmit clock toggle
    input wire logic send, // keep sending short frames
    output logic link_clk_pin, // transmit clock toward the phy, period twice HALF_NS
    output pbst_pkg::pbst_byte_t mac_tx // transmit pins toward the phy
);
    import pbst_pkg::*;
    int idx; // byte slot within a frame of 4 data and 4 idle
    logic [7:0] noise; // changing pattern for idle data lines
    // transmit clock stands low until run, then toggles free
    initial begin
        link_clk_pin = 1'b0;
        idx = 0;
        noise = 8'h3c;
        mac_tx = '{en: 1'b0, er: 1'b0, data: 8'hc3};
        #7;
        forever begin
            #(HALF_NS);
            link_clk_pin = run ? ~link_clk_pin : 1'b0;
        end
    end
    // short frames that the phy must ignore while generating
    always @(posedge link_clk_pin) begin
        noise <= noise + 8'h35;
        if (idx > 0 || send) begin
            mac_tx <= '{en: idx < 4, er: 1'b0, data: (idx < 4) ? 8'(8'h11 * idx) : ~noise};
            idx <= (idx == 7) ? 0 : idx + 1;
        end else begin
            mac_tx <= '{en: 1'b0, er: 1'b0, data: ~noise};
        end
    end
endmodule : pbst_mac_model

module pbst_stream_mon (
    input wire logic ref_clk, // sampling clock
    input wire logic clr, // zero all tallies, min_gap to its largest value
    input wire logic link_clk_pin, // byte pacing clock
    input wire pbst_pkg::pbst_byte_t strm, // watched stream
    input wire logic [7:0] exp_data, // expected byte
    input wire logic chk, // compare bytes with exp_data
    output int frames, // completed frames
    output int bytes, // bytes seen at link rising edges
    output int bad, // bytes unlike exp_data
    output int changes, // byte value changes
    output int min_gap, // least idle cycles between frames
    output int max_gap // most idle cycles between frames
);
    import pbst_pkg::*;
    logic link_q; // link clock one cycle ago
    logic en_q; // frame valid one cycle ago
    logic [7:0] prev; // last sampled byte
    int gap; // idle cycles so far
    // a byte stands a full link period, so sample it mid-way at link rise
    always @(posedge ref_clk) begin
        link_q <= link_clk_pin;
        en_q <= strm.en;
        gap <= strm.en ? 0 : gap + 1;
        if (clr) begin
            frames <= 0;
            bytes <= 0;
            bad <= 0;
            changes <= 0;
            min_gap <= 32'h7fffffff;
            max_gap <= 0;
        end else begin
            if (link_clk_pin && !link_q && strm.en) begin
                bytes <= bytes + 1;
                bad <= bad + int'(chk && strm.data !== exp_data);
                changes <= changes + int'(strm.data != prev);
                prev <= strm.data;
            end
            if (en_q && !strm.en) frames <= frames + 1;
            if (strm.en && !en_q && frames > 0) begin
                min_gap <= (gap < min_gap) ? gap : min_gap;
                max_gap <= (gap > max_gap) ? gap : max_gap;
            end
        end
    end
endmodule : pbst_stream_mon

// ### tb_top.sv
// Purpose: self-checking bench of the packet self-test core
// Assumes: 50 MHz reference clock, 160 ns link clock from the mac model
// Notes: register tasks hold each strobe for one edge, then idle one edge
`timescale 1ns/1ps
module tb_top;
    import pbst_pkg::*;
    logic ref_clk, rst, link_clk_pin, loopback_en, mgmt_wr, mgmt_rd, bist_busy;
    logic run, send, clr, chk;
    pbst_byte_t mac_tx, med_rx, med_tx, mac_rx;
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata;
    logic [7:0] exp_data;
    int failures, checks_done, d_frames, d_bytes, d_bad, d_chg, d_min, d_max, n;
    int l_frames, l_bytes, l_bad, l_min, l_max;
    pbst_core #(.FIFO_DEPTH(4)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .link_clk_pin(link_clk_pin), .mac_tx(mac_tx), .med_rx(med_rx),
        .loopback_en(loopback_en), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
        .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .med_tx(med_tx), .mac_rx(mac_rx), .bist_busy(bist_busy));
    pbst_mac_model #(.HALF_NS(80)) u_mac (.run(run), .send(send),
        .link_clk_pin(link_clk_pin), .mac_tx(mac_tx));
    // tallies of the media stream
    pbst_stream_mon u_mon_med (.ref_clk(ref_clk), .clr(clr), .link_clk_pin(link_clk_pin),
        .strm(med_tx), .exp_data(exp_data), .chk(chk), .frames(d_frames), .bytes(d_bytes),
        .bad(d_bad), .changes(d_chg), .min_gap(d_min), .max_gap(d_max));
    // tallies of the stream toward the mac
    pbst_stream_mon u_mon_mac (.ref_clk(ref_clk), .clr(clr), .link_clk_pin(link_clk_pin),
        .strm(mac_rx), .exp_data(exp_data), .chk(chk), .frames(l_frames), .bytes(l_bytes),
        .bad(l_bad), .changes(), .min_gap(l_min), .max_gap(l_max));
    // free-running reference clock
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check16
    task automatic check_num(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_num
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step
    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_addr = a;
        mgmt_wdata = d;
        mgmt_wr = 1'b1;
        step();
        mgmt_wr = 1'b0;
        step();
    endtask : reg_wr
    // read data is registered one edge after the strobe
    task automatic reg_chk(input logic [4:0] a, input logic [15:0] exp);
        mgmt_addr = a;
        mgmt_rd = 1'b1;
        step();
        mgmt_rd = 1'b0;
        check16(mgmt_rdata, exp);
        step();
    endtask : reg_chk
    // bounded wait: 0 for idle, 1 for media frames, 2 for media bytes
    task automatic wait_for(input int what, input int cnt, input int max);
        int k;
        k = 0;
        while (k < max && (what == 0 ? bist_busy !== 1'b0 :
               (what == 1 ? d_frames : d_bytes) < cnt)) begin
            step();
            k++;
        end
        if (k >= max) begin
            failures++;
            $display("unexpected at %0t: wait %h expired after %h", $time, what, max);
            wrap_up();
        end
    endtask : wait_for
    task automatic clear_mon();
        clr = 1'b1;
        step();
        clr = 1'b0;
    endtask : clear_mon
    task automatic drive_rx(input logic en, input logic er);
        med_rx = '{en: en, er: er, data: 8'h5a};
        step();
    endtask : drive_rx
    // main sequence
    initial begin
        rst = 1'b1;
        {loopback_en, mgmt_wr, mgmt_rd, run, send, chk} = '0;
        clr = 1'b1;
        mgmt_addr = 5'h00;
        mgmt_wdata = 16'h0000;
        exp_data = 8'h00;
        med_rx = BYTE_IDLE;
        failures = 0;
        checks_done = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        clr = 1'b0;
        run = 1'b1;
        // reset values and unmapped place
        reg_chk(REG_CNT_VIEW, 16'h0000);
        reg_chk(REG_CFG_ONE, CFG_ONE_RST);
        reg_chk(REG_CFG_TWO, CFG_TWO_RST);
        reg_chk(5'h1b, 16'h0000);
        reg_wr(REG_CFG_ONE, 16'h77ff);
        reg_chk(REG_CFG_ONE, 16'h34ff);
        reg_wr(REG_CFG_ONE, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            reg_wr(REG_CFG_TWO, 16'h4123 | (16'(c) << 11));
            reg_chk(REG_CFG_TWO, 16'h4123 | (16'(c) << 11));
        end
        $display("test registers done");
        // one user frame to the media while the mac keeps sending
        reg_wr(REG_CFG_TWO, 16'h0800);
        clear_mon();
        exp_data = 8'ha5;
        chk = 1'b1;
        reg_wr(REG_CFG_ONE, 16'h08a5);
        check16({15'h0000, bist_busy}, 16'h0001);
        send = 1'b1;
        wait_for(2, 30, 1000);
        send = 1'b0;
        wait_for(0, 0, 2000);
        check_num(d_frames, 1);
        check_num(d_bytes, 60);
        check_num(d_bad, 0);
        check_num(l_frames, 0);
        reg_chk(REG_CFG_ONE, 16'h00a5);
        $display("test single frame done");
        // ten looped frames counted as packets
        loopback_en = 1'b1;
        exp_data = 8'h3c;
        reg_wr(REG_CFG_TWO, 16'h9000);
        clear_mon();
        reg_wr(REG_CFG_ONE, 16'h483c);
        wait_for(0, 0, 20000);
        check_num(l_frames, 10);
        check_num(l_bytes, 600);
        check_num(l_bad, 0);
        check_num(d_frames, 0);
        check_num(int'(l_min >= 5 && l_max < 480), 1);
        reg_chk(REG_CNT_VIEW, 16'h000a);
        reg_wr(REG_CFG_TWO, 16'hd000);
        reg_chk(REG_CNT_VIEW, 16'h0000);
        // clear, then a looped frame with the counter off
        reg_wr(REG_CFG_TWO, 16'h0800);
        reg_wr(REG_CFG_ONE, 16'h4000);
        reg_chk(REG_CNT_VIEW, 16'h0000);
        clear_mon();
        reg_wr(REG_CFG_ONE, 16'h0800);
        wait_for(0, 0, 2000);
        check_num(l_frames, 1);
        reg_chk(REG_CNT_VIEW, 16'h0000);
        $display("test loopback count done");
        // error counting on received traffic, two errors per frame
        loopback_en = 1'b0;
        reg_wr(REG_CFG_TWO, 16'h8000);
        reg_wr(REG_CFG_ONE, 16'hc000);
        repeat (3) begin
            drive_rx(1'b1, 1'b1);
            drive_rx(1'b1, 1'b0);
            drive_rx(1'b1, 1'b1);
            drive_rx(1'b1, 1'b0);
            check16({6'h00, mac_rx}, {6'h00, med_rx});
            drive_rx(1'b0, 1'b0);
        end
        step();
        step();
        reg_chk(REG_CNT_VIEW, 16'h0006);
        $display("test error count done");
        // pseudo random long frame
        reg_wr(REG_CFG_TWO, 16'h0800);
        clear_mon();
        chk = 1'b0;
        reg_wr(REG_CFG_ONE, 16'h2c00);
        wait_for(0, 0, 16000);
        check_num(d_bytes, 1514);
        check_num(int'(d_chg >= 1000), 1);
        $display("test random frame done");
        // continuous with long gap, stopped by software
        reg_wr(REG_CFG_TWO, 16'h0000);
        clear_mon();
        chk = 1'b1;
        exp_data = 8'h77;
        reg_wr(REG_CFG_ONE, 16'h1877);
        wait_for(1, 2, 4000);
        reg_chk(REG_CFG_ONE, 16'h1877);
        check_num(int'(d_min >= 480), 1);
        reg_wr(REG_CFG_ONE, 16'h1077);
        wait_for(0, 0, 3000);
        n = d_frames;
        repeat (1500) step();
        check_num(d_frames, n);
        check_num(d_bad, 0);
        $display("test continuous done");
        wrap_up();
    end
endmodule : tb_top
